/* include/trhp_cfg.svh */
// Offsets, field positions, reset values and cycle counts of the reconfiguration host port.
`ifndef TRHP_CFG_SVH
`define TRHP_CFG_SVH

`define TRHP_ADDR_CTRL       8'h00
`define TRHP_ADDR_STATUS     8'h04
`define TRHP_ADDR_IRQ_STAT   8'h08
`define TRHP_ADDR_IRQ_MASK   8'h0c
`define TRHP_ADDR_IMG_LEN    8'h10

`define TRHP_CTRL_PMA        0
`define TRHP_CTRL_CONT       1
`define TRHP_CTRL_LAT_LSB    4
`define TRHP_CTRL_LAT_MSB    7
`define TRHP_CTRL_RESET      8'h10
`define TRHP_IMG_LEN_RESET   8'h08
`define TRHP_IRQ_MASK_RESET  3'h0

`define TRHP_IRQ_OCAL_DONE   0
`define TRHP_IRQ_XFER_DONE   1
`define TRHP_IRQ_ERROR       2

`define TRHP_RX_CHANNELS     4
`define TRHP_OCAL_CYC_PER_CH 16
`define TRHP_WORD_WR_CYC     8'h04
`define TRHP_PMA_CYC         8'h06
`define TRHP_ERR_CYC         8'h02
`define TRHP_REG_FETCH_LAT   8'h01

`endif

/* include/trhp_pkg.sv */
// Types shared by the reconfiguration host port modules.
package trhp_pkg;

    typedef enum logic [2:0]
    {
        ST_PWRUP  = 3'b000,
        ST_OCAL   = 3'b001,
        ST_IDLE   = 3'b010,
        ST_FETCH  = 3'b011,
        ST_WRWORD = 3'b100,
        ST_PMA_WR = 3'b101,
        ST_PMA_RD = 3'b110,
        ST_ERR    = 3'b111
    } trhp_state_t;

    typedef logic [7:0]  trhp_byte_t;
    typedef logic [15:0] trhp_word_t;
    typedef logic [31:0] trhp_bus_t;

endpackage : trhp_pkg

/* core/trhp_wb_regs.sv */
// Wishbone register file with sticky interrupt status for the reconfiguration host port.
`timescale 1ns/100ps
`include "trhp_cfg.svh"
module trhp_wb_regs
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire trhp_pkg::trhp_byte_t wbAdr,
    input  wire trhp_pkg::trhp_bus_t  wbDatW,
    output      trhp_pkg::trhp_bus_t  wbDatR,
    input  wire logic                wbWe,
    input  wire logic [3:0]          wbSel,
    input  wire logic                wbCyc,
    input  wire logic                wbStb,
    output      logic                wbAck,
    input  wire logic [2:0]          events,
    input  wire logic [3:0]          stateView,
    output      logic                ctrlPma,
    output      logic                ctrlCont,
    output      logic [3:0]          ctrlLat,
    output      trhp_pkg::trhp_byte_t imgLen,
    output      logic                irq
);
    import trhp_pkg::*;

    function automatic logic hit(input trhp_byte_t adr, input trhp_byte_t off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    trhp_byte_t ctrl;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    trhp_bus_t  rdMux;

    wire access  = wbCyc & wbStb & ~wbAck;
    wire wrLow   = access & wbWe & wbSel[0];
    wire rdStat  = access & ~wbWe & hit(wbAdr, `TRHP_ADDR_IRQ_STAT);
    wire [2:0] next_irqStat = (irqStat & {3{~rdStat}}) | events;

    assign ctrlPma  = ctrl[`TRHP_CTRL_PMA];
    assign ctrlCont = ctrl[`TRHP_CTRL_CONT];
    assign ctrlLat  = ctrl[`TRHP_CTRL_LAT_MSB:`TRHP_CTRL_LAT_LSB];
    assign irq      = |(irqStat & irqMask);

    assign rdMux = hit(wbAdr, `TRHP_ADDR_CTRL)     ? {24'h000000, ctrl}         :
                   hit(wbAdr, `TRHP_ADDR_STATUS)   ? {28'h0000000, stateView}   :
                   hit(wbAdr, `TRHP_ADDR_IRQ_STAT) ? {29'h00000000, irqStat}    :
                   hit(wbAdr, `TRHP_ADDR_IRQ_MASK) ? {29'h00000000, irqMask}    :
                   hit(wbAdr, `TRHP_ADDR_IMG_LEN)  ? {24'h000000, imgLen}       :
                   32'h00000000;

    // A read of the interrupt status register clears it, but an event in the same cycle is kept.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wbAck   <= 1'b0;
            wbDatR  <= 32'h00000000;
            ctrl    <= `TRHP_CTRL_RESET;
            imgLen  <= `TRHP_IMG_LEN_RESET;
            irqMask <= `TRHP_IRQ_MASK_RESET;
            irqStat <= 3'h0;
        end
        else
        begin
            wbAck   <= access;
            wbDatR  <= access ? rdMux : wbDatR;
            irqStat <= next_irqStat;
            if (wrLow && hit(wbAdr, `TRHP_ADDR_CTRL))
                ctrl <= wbDatW[7:0];
            if (wrLow && hit(wbAdr, `TRHP_ADDR_IMG_LEN))
                imgLen <= wbDatW[7:0];
            if (wrLow && hit(wbAdr, `TRHP_ADDR_IRQ_MASK))
                irqMask <= wbDatW[2:0];
        end
    end

endmodule : trhp_wb_regs

/* core/trhp_host_port.sv */
// Fabric-facing control port of the transceiver reconfiguration controller.
`timescale 1ns/100ps
`include "trhp_cfg.svh"
module trhp_host_port
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire trhp_pkg::trhp_byte_t wbAdr,
    input  wire trhp_pkg::trhp_bus_t  wbDatW,
    output      trhp_pkg::trhp_bus_t  wbDatR,
    input  wire logic                 wbWe,
    input  wire logic [3:0]           wbSel,
    input  wire logic                 wbCyc,
    input  wire logic                 wbStb,
    output      logic                 wbAck,
    output      logic                 irq,
    input  wire logic                 writeAll,
    input  wire logic                 readStrobe,
    input  wire trhp_pkg::trhp_word_t pmaWriteValue,
    output      logic                 busy,
    output      logic                 dataValid,
    output      logic                 error,
    output      trhp_pkg::trhp_word_t pmaReadValue,
    output      trhp_pkg::trhp_byte_t imgAddr,
    input  wire trhp_pkg::trhp_word_t imgData,
    output      trhp_pkg::trhp_word_t gxbData,
    output      trhp_pkg::trhp_byte_t gxbAddr,
    output      logic                 gxbWrite
);
    import trhp_pkg::*;

    localparam trhp_byte_t OCAL_TOTAL =
        8'(`TRHP_RX_CHANNELS * `TRHP_OCAL_CYC_PER_CH);

    // A latency of zero cannot fetch anything, so it is treated as one cycle.
    function automatic trhp_byte_t fetchWait(input logic cont, input logic [3:0] lat);
        if (!cont)
            fetchWait = `TRHP_REG_FETCH_LAT - 8'h01;
        else if (lat == 4'h0)
            fetchWait = 8'h00;
        else
            fetchWait = {4'h0, lat} - 8'h01;
    endfunction : fetchWait

    trhp_state_t state;
    trhp_state_t next_state;
    trhp_byte_t  cnt;
    trhp_byte_t  next_cnt;
    trhp_byte_t  wordIdx;
    trhp_byte_t  next_wordIdx;
    trhp_byte_t  next_imgAddr;
    trhp_word_t  pmaPending;
    trhp_word_t  next_pmaPending;
    trhp_word_t  pmaStore;
    trhp_word_t  next_pmaStore;
    logic        next_gxbWrite;
    logic        next_dataValid;
    logic        evOcal;
    logic        evXfer;
    logic        ctrlPma;
    logic        ctrlCont;
    logic [3:0]  ctrlLat;
    trhp_byte_t  imgLen;

    wire cntDone    = (cnt == 8'h00);
    wire anyStrobe  = writeAll | readStrobe;
    wire lastWord   = (imgAddr == imgLen - 8'h01);
    wire inTransfer = (state == ST_FETCH) || (state == ST_WRWORD) ||
                      (state == ST_PMA_WR) || (state == ST_PMA_RD);
    // Strobes during power-up or offset cancellation are ignored rather than flagged,
    // so that a careless fabric cannot abort the calibration.
    wire unsupported = (inTransfer && anyStrobe) ||
                       (state == ST_IDLE && writeAll && readStrobe) ||
                       (state == ST_IDLE && readStrobe && !ctrlPma);

    assign busy  = (state == ST_OCAL) || inTransfer;
    assign error = (state == ST_ERR);

    trhp_wb_regs u_regs
    (
        .clk       (clk),
        .resetn    (resetn),
        .wbAdr     (wbAdr),
        .wbDatW    (wbDatW),
        .wbDatR    (wbDatR),
        .wbWe      (wbWe),
        .wbSel     (wbSel),
        .wbCyc     (wbCyc),
        .wbStb     (wbStb),
        .wbAck     (wbAck),
        .events    ({error, evXfer, evOcal}),
        .stateView ({busy, state}),
        .ctrlPma   (ctrlPma),
        .ctrlCont  (ctrlCont),
        .ctrlLat   (ctrlLat),
        .imgLen    (imgLen),
        .irq       (irq)
    );

    always_comb
    begin
        next_state      = state;
        next_cnt        = cntDone ? 8'h00 : cnt - 8'h01;
        next_wordIdx    = wordIdx;
        next_imgAddr    = imgAddr;
        next_pmaPending = pmaPending;
        next_pmaStore   = pmaStore;
        next_gxbWrite   = 1'b0;
        next_dataValid  = 1'b0;
        evOcal          = 1'b0;
        evXfer          = 1'b0;
        if (unsupported)
        begin
            next_state = ST_ERR;
            next_cnt   = `TRHP_ERR_CYC - 8'h01;
        end
        else
        begin
            case (state)
                ST_PWRUP:
                begin
                    next_state = ST_OCAL;
                    next_cnt   = OCAL_TOTAL - 8'h01;
                end
                ST_OCAL:
                begin
                    if (cntDone)
                    begin
                        next_state = ST_IDLE;
                        evOcal     = 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (writeAll && ctrlPma)
                    begin
                        next_state      = ST_PMA_WR;
                        next_cnt        = `TRHP_PMA_CYC - 8'h01;
                        next_pmaPending = pmaWriteValue;
                    end
                    else if (writeAll)
                    begin
                        next_state   = ST_FETCH;
                        next_cnt     = fetchWait(ctrlCont, ctrlLat);
                        next_imgAddr = ctrlCont ? 8'h00 : wordIdx;
                    end
                    else if (readStrobe)
                    begin
                        next_state = ST_PMA_RD;
                        next_cnt   = `TRHP_PMA_CYC - 8'h01;
                    end
                end
                ST_FETCH:
                begin
                    if (cntDone)
                    begin
                        next_state    = ST_WRWORD;
                        next_cnt      = `TRHP_WORD_WR_CYC - 8'h01;
                        next_gxbWrite = 1'b1;
                    end
                end
                ST_WRWORD:
                begin
                    if (cntDone && ctrlCont && !lastWord)
                    begin
                        next_state   = ST_FETCH;
                        next_cnt     = fetchWait(1'b1, ctrlLat);
                        next_imgAddr = imgAddr + 8'h01;
                    end
                    else if (cntDone)
                    begin
                        next_state   = ST_IDLE;
                        evXfer       = 1'b1;
                        next_wordIdx = (ctrlCont || lastWord) ? 8'h00 : imgAddr + 8'h01;
                    end
                end
                ST_PMA_WR:
                begin
                    if (cntDone)
                    begin
                        next_state    = ST_IDLE;
                        next_pmaStore = pmaPending;
                        evXfer        = 1'b1;
                    end
                end
                ST_PMA_RD:
                begin
                    if (cntDone)
                    begin
                        next_state     = ST_IDLE;
                        next_dataValid = 1'b1;
                        evXfer         = 1'b1;
                    end
                end
                ST_ERR:
                begin
                    if (cntDone)
                        next_state = ST_IDLE;
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state        <= ST_PWRUP;
            cnt          <= 8'h00;
            wordIdx      <= 8'h00;
            imgAddr      <= 8'h00;
            pmaPending   <= 16'h0000;
            pmaStore     <= 16'h0000;
            pmaReadValue <= 16'h0000;
            gxbData      <= 16'h0000;
            gxbAddr      <= 8'h00;
            gxbWrite     <= 1'b0;
            dataValid    <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            cnt          <= next_cnt;
            wordIdx      <= next_wordIdx;
            imgAddr      <= next_imgAddr;
            pmaPending   <= next_pmaPending;
            pmaStore     <= next_pmaStore;
            pmaReadValue <= next_dataValid ? pmaStore : pmaReadValue;
            gxbData      <= next_gxbWrite ? imgData : gxbData;
            gxbAddr      <= next_gxbWrite ? imgAddr : gxbAddr;
            gxbWrite     <= next_gxbWrite;
            dataValid    <= next_dataValid;
        end
    end

    // Helper counters that only the checks below read.
    trhp_byte_t ocalRun;
    trhp_byte_t fetchRun;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ocalRun  <= 8'h00;
            fetchRun <= 8'h00;
        end
        else
        begin
            ocalRun  <= (state == ST_OCAL) ? ocalRun + 8'h01 : 8'h00;
            fetchRun <= (state == ST_FETCH && next_state == ST_FETCH) ? fetchRun + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence pmaWriteTaken;
        state == ST_IDLE && writeAll && ctrlPma && !unsupported;
    endsequence

    sequence pmaReadTaken;
        state == ST_IDLE && readStrobe && !unsupported;
    endsequence

    sequence busyWindowOfPma;
        busy [*6] ##1 !busy;
    endsequence

    AST_PWRUP_LOW_THEN_HIGH: assert property (
        state == ST_PWRUP |-> !busy ##1 busy)
        else $error("Busy did not stay low one cycle after reset and then rise.");

    AST_OCAL_BUSY: assert property (
        state == ST_OCAL |-> busy && !error)
        else $error("Busy dropped during offset cancellation.");

    AST_OCAL_DONE: assert property (
        state == ST_OCAL && next_state != ST_OCAL |-> ocalRun == OCAL_TOTAL - 8'h01 ##1 !busy)
        else $error("Offset cancellation ended at the wrong time or busy stayed high.");

    AST_PMA_WRITE_BUSY: assert property (
        pmaWriteTaken |=> busyWindowOfPma)
        else $error("Busy window of an analog write has the wrong length.");

    AST_PMA_READ_VALID: assert property (
        pmaReadTaken |=> busyWindowOfPma and (!dataValid [*6] ##1 dataValid))
        else $error("Data valid did not follow an analog read at the expected cycle.");

    AST_VALID_ONLY_AFTER_READ: assert property (
        dataValid |-> $past(state) == ST_PMA_RD && !busy)
        else $error("Data valid raised outside an analog read.");

    AST_CHANNEL_WRITE_BUSY: assert property (
        gxbWrite |-> busy && state == ST_WRWORD && gxbAddr == $past(imgAddr))
        else $error("Channel word written while busy was low or at the wrong address.");

    AST_CONT_NEXT_WORD: assert property (
        state == ST_WRWORD && cntDone && ctrlCont && !lastWord && !anyStrobe
        |=> state == ST_FETCH && imgAddr == $past(imgAddr) + 8'h01)
        else $error("Continuous write stopped before the last image word.");

    AST_FETCH_LATENCY: assert property (
        state == ST_FETCH && next_state == ST_WRWORD
        |-> fetchRun == fetchWait(ctrlCont, ctrlLat))
        else $error("Image fetch latency differs from the configured value.");

    AST_ERROR_TWO: assert property (
        unsupported |=> (error && !busy) [*2] ##1 !error)
        else $error("Error was not shown for exactly two cycles with busy low.");

endmodule : trhp_host_port

/* verif/trhp_fabric_model.sv */
// Fabric-side partner: transaction strobe source and settings image memory.
`timescale 1ns/100ps
module trhp_fabric_model
(
    input  wire logic                 clk,
    input  wire logic                 busy,
    input  wire logic                 error,
    input  wire trhp_pkg::trhp_byte_t imgAddr,
    output      trhp_pkg::trhp_word_t imgData,
    output      logic                 writeAll,
    output      logic                 readStrobe
);
    import trhp_pkg::*;

    // Each word carries its own address, so a word fetched from the wrong place shows at once.
    assign imgData = {~imgAddr, imgAddr};

    initial
    begin
        writeAll   = 1'b0;
        readStrobe = 1'b0;
    end

    // Both strobes together are only sent when a scenario asks for a refusal.
    // Only the bench watchdog ends this wait, so a controller stuck busy fails the run.
    task pulse(input logic wr, input logic rd);
        while (busy !== 1'b0 || error !== 1'b0)
        begin
            @(posedge clk);
        end
        writeAll   <= wr;
        readStrobe <= rd;
        @(posedge clk);
        writeAll   <= 1'b0;
        readStrobe <= 1'b0;
    endtask : pulse
endmodule : trhp_fabric_model

/* verif/trhp_host_port_test.sv */
// Self-checking testbench of the reconfiguration host port.
`timescale 1ns/100ps
`include "trhp_cfg.svh"
module trhp_host_port_test;
    import trhp_pkg::*;

    logic       clk, resetn, wbWe, wbCyc, wbStb, wbAck, irq;
    logic       writeAll, readStrobe, busy, dataValid, error, gxbWrite;
    logic [3:0] wbSel;
    trhp_byte_t wbAdr, imgAddr, gxbAddr;
    trhp_bus_t  wbDatW, wbDatR, rd;
    trhp_word_t pmaWriteValue, pmaReadValue, imgData, gxbData, v;
    int         n_mismatch = 0;
    int         checks = 0;
    int         imgLen, c, lat, expCnt;
    int         expQ[$];

    trhp_host_port DUT (.clk(clk), .resetn(resetn), .wbAdr(wbAdr), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbWe(wbWe), .wbSel(wbSel), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbAck(wbAck), .irq(irq), .writeAll(writeAll), .readStrobe(readStrobe),
        .pmaWriteValue(pmaWriteValue), .busy(busy), .dataValid(dataValid), .error(error),
        .pmaReadValue(pmaReadValue), .imgAddr(imgAddr), .imgData(imgData),
        .gxbData(gxbData), .gxbAddr(gxbAddr), .gxbWrite(gxbWrite));

    trhp_fabric_model fabric (.clk(clk), .busy(busy), .error(error), .imgAddr(imgAddr),
        .imgData(imgData), .writeAll(writeAll), .readStrobe(readStrobe));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task summarize();
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Classic single Wishbone cycle; ack and read data are taken at the same edge.
    // The master waits for ack as long as it takes; only the watchdog ends the wait.
    task wb(input trhp_byte_t a, input trhp_bus_t d, input logic we, output trhp_bus_t q);
        wbAdr  <= a;
        wbDatW <= d;
        wbWe   <= we;
        wbSel  <= 4'h1;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
        chk("wbAck drop", 0, wbAck);
    endtask : wb

    // Counts the sampled cycles with busy high, up to 2000; returns at the first edge that samples it low.
    task busyRun(output int cnt);
        cnt = 0;
        @(posedge clk);
        while (busy === 1'b1 && cnt < 2000)
        begin
            cnt++;
            @(posedge clk);
        end
    endtask : busyRun

    // Every channel word written is compared with the next word the model expects.
    always @(posedge clk)
    begin : mon
        int k;
        if (gxbWrite === 1'b1)
        begin
            if (expQ.size() == 0)
                chk("spurious gxbWrite", 0, 1);
            else
            begin
                k = expQ.pop_front();
                chk("gxbAddr", k, gxbAddr);
                chk("gxbData", {~k[7:0], k[7:0]}, gxbData);
            end
        end
    end

    initial
    begin
        #(20000 * 50);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        void'($urandom(32'h5a56502c));
        resetn = 1'b0;
        wbAdr = 8'h00;
        wbDatW = 32'h0;
        wbWe = 1'b0;
        wbSel = 4'h0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        pmaWriteValue = 16'h0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("busy first cycle", 0, busy);
        busyRun(c);
        chk("offset cancel busy", `TRHP_RX_CHANNELS * `TRHP_OCAL_CYC_PER_CH, c);
        chk("irq masked", 0, irq);
        wb(`TRHP_ADDR_STATUS, 32'h0, 1'b0, rd);
        chk("status idle", {1'b0, ST_IDLE}, rd);
        wb(`TRHP_ADDR_CTRL, 32'h0, 1'b0, rd);
        chk("ctrl reset", `TRHP_CTRL_RESET, rd);
        wb(`TRHP_ADDR_IMG_LEN, 32'h0, 1'b0, rd);
        chk("img len reset", `TRHP_IMG_LEN_RESET, rd);
        wb(`TRHP_ADDR_IRQ_MASK, 32'h0, 1'b0, rd);
        chk("mask reset", `TRHP_IRQ_MASK_RESET, rd);
        wb(8'h20, 32'h0, 1'b0, rd);
        chk("unmapped read", 0, rd);
        wb(`TRHP_ADDR_IRQ_MASK, 32'h7, 1'b1, rd);
        chk("irq offset done", 1, irq);
        wb(`TRHP_ADDR_IRQ_STAT, 32'h0, 1'b0, rd);
        chk("irq stat", 1, rd);
        chk("irq cleared", 0, irq);
        wb(`TRHP_ADDR_CTRL, 32'h1, 1'b1, rd);
        repeat (3)
        begin
            v = trhp_word_t'($urandom);
            pmaWriteValue <= v;
            fabric.pulse(1'b1, 1'b0);
            busyRun(c);
            chk("analog write busy", `TRHP_PMA_CYC, c);
            fabric.pulse(1'b0, 1'b1);
            busyRun(c);
            chk("analog read busy", `TRHP_PMA_CYC, c);
            chk("dataValid", 1, dataValid);
            chk("pmaReadValue", v, pmaReadValue);
        end
        // Both strobes at once in analog mode, then a read in channel mode.
        for (int i = 0; i < 2; i++)
        begin
            wb(`TRHP_ADDR_IRQ_STAT, 32'h0, 1'b0, rd);
            wb(`TRHP_ADDR_CTRL, (i == 0) ? 32'h1 : 32'h0, 1'b1, rd);
            fabric.pulse(i == 0, 1'b1);
            @(posedge clk);
            chk("error busy", 0, busy);
            chk("error first", 1, error);
            @(posedge clk);
            chk("error second", 1, error);
            @(posedge clk);
            chk("error end", 0, error);
            chk("irq on error", 1, irq);
            wb(`TRHP_ADDR_IRQ_STAT, 32'h0, 1'b0, rd);
            chk("error stat", 1, rd[2]);
        end
        imgLen = 2 + ($urandom % 4);
        wb(`TRHP_ADDR_IMG_LEN, imgLen, 1'b1, rd);
        for (int i = 0; i < imgLen + 2; i++)
        begin
            expQ.push_back(i % imgLen);
            fabric.pulse(1'b1, 1'b0);
            busyRun(c);
            chk("word busy", `TRHP_REG_FETCH_LAT + `TRHP_WORD_WR_CYC, c);
        end
        chk("words left", 0, expQ.size());
        wb(`TRHP_ADDR_IRQ_STAT, 32'h0, 1'b0, rd);
        chk("transfer stat", 1, rd[1]);
        for (lat = 0; lat < 4; lat++)
        begin
            wb(`TRHP_ADDR_CTRL, (lat << 4) | 2, 1'b1, rd);
            for (int i = 0; i < imgLen; i++)
                expQ.push_back(i);
            fabric.pulse(1'b1, 1'b0);
            busyRun(c);
            expCnt = imgLen * (((lat == 0) ? 1 : lat) + `TRHP_WORD_WR_CYC);
            chk("image busy", expCnt, c);
            chk("image words left", 0, expQ.size());
        end
        summarize();
    end
endmodule : trhp_host_port_test
